// ==== hw/pwr_mode_pkg.sv ====
// package for the power-mode and wake-up supervisor: register map, fields, timing.
// assumes a 250 MHz system clock and an AXI4-Lite master for firmware access.
// How it works
// - four modes: hard power-down, standby, suspend, active; active fully configurable.
// - standby runs from slow oscillator, main regulator low-power, wake sources powered.
// - pad regulator standby mode selectable active/low-power/off, default low-power.
// - standby only on firmware request, contact interface deactivated first.
// - standby refused on host traffic, pending wake, field detector off while field wake enabled, no pad supply.
// - suspend stops every clock source except the slow oscillator.
// - interrupt to firmware after more than 3 ms without USB activity.
// - suspend refused on same four conditions; contact interface deactivated first.
// - wake-enabled GPIO wakes only on a rising edge.
// - host wake only from interface selected before entry; USB only for suspend.
// - every wake source has its own enable bit.
// - hard power-down stops all clocks and regulators except main in low-power.
// - enter hard power-down on low pin, or supply below 2.3 V with auto option.
// - leave hard power-down only when pin high and supply above 2.3 V.
// - brown-out flag on selected supply level, readable, optionally interrupting.
// - either main-supply level selectable to force hard power-down.
// - card-supply monitor flags below selected level, optional contact deactivation.
// - temperature trip level 135/130/125/120 C selectable, resets to 120; the field is only stored and read back, it drives no output.
// - temperature trip raises interrupt and records which sensor tripped.
// - after thermal standby, wake only when both sensors are below limit.
package pwr_mode_pkg;
  localparam int unsigned AW = 8;
  localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [AW-1:0] OFS_WAKEEN = 8'h04;
  localparam logic [AW-1:0] OFS_THR    = 8'h08;
  localparam logic [AW-1:0] OFS_STAT   = 8'h0c;
  localparam logic [AW-1:0] OFS_IRQ    = 8'h10;
  localparam logic [AW-1:0] OFS_IRQEN  = 8'h14;
  // ctrl fields
  localparam int unsigned C_STBY_REQ = 0;
  localparam int unsigned C_SUSP_REQ = 1;
  localparam int unsigned C_PAD_LO   = 2;
  localparam int unsigned C_AUTO_HPD = 4;
  localparam int unsigned C_CT_AUTO  = 5;
  localparam int unsigned C_HOST_LO  = 6;
  // wake enable bits
  localparam int unsigned NWAKE   = 8;
  localparam int unsigned W_HOST  = 0;
  localparam int unsigned W_FIELD = 1;
  localparam int unsigned W_GPIO  = 2;
  localparam int unsigned W_CARD  = 3;
  localparam int unsigned W_AUX   = 4;
  localparam int unsigned W_CNT   = 5;
  localparam int unsigned W_OVER  = 6;
  localparam int unsigned W_TEMP  = 7;
  // threshold fields
  localparam int unsigned T_BOD_LO  = 0;
  localparam int unsigned T_HPD_LO  = 1;
  localparam int unsigned T_CARD_LO = 2;
  localparam int unsigned T_TEMP_LO = 4;
  localparam logic [1:0] PAD_ACTIVE = 2'h0;
  localparam logic [1:0] PAD_LOWPWR = 2'h1;
  localparam logic [1:0] PAD_OFF    = 2'h2;
  localparam logic [1:0] TEMP_120   = 2'h3;
  localparam logic [1:0] HOST_USB   = 2'h3;
  // irq bits
  localparam int unsigned I_USB  = 0;
  localparam int unsigned I_BOD  = 1;
  localparam int unsigned I_CARD = 2;
  localparam int unsigned I_T0   = 3;
  localparam int unsigned I_T1   = 4;
  localparam int unsigned NIRQ   = 5;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam int unsigned CLK_MHZ    = 250;
  localparam int unsigned USB_IDLE_US = 3000;
  localparam int unsigned USB_IDLE_CYC = USB_IDLE_US * CLK_MHZ;
  typedef enum logic [2:0] {M_ACTIVE, M_DEACT, M_STANDBY, M_SUSPEND, M_HPD} mode_t;
endpackage

// ==== hw/pwr_mode_sup.sv ====
// power-mode and wake-up supervisor with AXI4-Lite register slave.
// assumes analog monitor and pin inputs are asynchronous; they are synchronised here.
`timescale 1ns/1ps
module pwr_mode_sup #(
  parameter int unsigned USB_IDLE = pwr_mode_pkg::USB_IDLE_CYC
) (
  input  wire logic                      SYS_CLK,
  input  wire logic                      RST_N,
  input  wire logic [pwr_mode_pkg::AW-1:0] S_AXI_AWADDR,
  input  wire logic                      S_AXI_AWVALID,
  output logic                           S_AXI_AWREADY,
  input  wire logic [31:0]               S_AXI_WDATA,
  input  wire logic [3:0]                S_AXI_WSTRB,
  input  wire logic                      S_AXI_WVALID,
  output logic                           S_AXI_WREADY,
  output logic [1:0]                     S_AXI_BRESP,
  output logic                           S_AXI_BVALID,
  input  wire logic                      S_AXI_BREADY,
  input  wire logic [pwr_mode_pkg::AW-1:0] S_AXI_ARADDR,
  input  wire logic                      S_AXI_ARVALID,
  output logic                           S_AXI_ARREADY,
  output logic [31:0]                    S_AXI_RDATA,
  output logic [1:0]                     S_AXI_RRESP,
  output logic                           S_AXI_RVALID,
  input  wire logic                      S_AXI_RREADY,
  input  wire logic                      HPD_PIN,
  input  wire logic                      MAIN_ABOVE_2V3,
  input  wire logic                      MAIN_ABOVE_2V7,
  input  wire logic                      MON_B_ABOVE_4V0,
  input  wire logic [2:0]                CARD_ABOVE,
  input  wire logic [1:0]                TEMP_HOT,
  input  wire logic                      HOST_BUSY,
  input  wire logic [3:0]                HOST_WAKE,
  input  wire logic                      USB_ACTIVITY,
  input  wire logic                      FIELD_DET_ON,
  input  wire logic                      FIELD_PRESENT,
  input  wire logic                      GPIO_WAKE,
  input  wire logic                      CARD_EVENT,
  input  wire logic                      AUX_IRQ,
  input  wire logic                      WAKE_COUNTER,
  input  wire logic                      OVERLOAD,
  input  wire logic                      PAD_SUPPLY_OK,
  input  wire logic                      CT_DEACT_DONE,
  output logic                           CT_DEACT_REQ,
  output logic [2:0]                     MODE,
  output logic                           FAST_CLKS_ON,
  output logic                           SLOW_OSC_ON,
  output logic                           MAIN_REG_LOWPWR,
  output logic [1:0]                     PAD_REG_MODE,
  output logic                           OTHER_REGS_ON,
  output logic                           CPU_IRQ
);
  import pwr_mode_pkg::*;

  // twenty pin and monitor lines pass the two-flop synchroniser
  localparam int unsigned NSYNC = 20;
  // reset to the idle pin levels so release raises no false hpd, flag or request
  localparam logic [NSYNC-1:0] SYNC_IDLE = 20'hfe302;
  // highest card monitor level; a larger select code falls back to it
  localparam logic [1:0] CARD_TOP = 2'h2;
  localparam int unsigned CW = $clog2(USB_IDLE + 2);

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic             gpio_d;
    mode_t            mode;
    logic             to_susp;
    logic             thermal;
    logic [7:0]       ctrl;
    logic [NWAKE-1:0] wake_en;
    logic [5:0]       thr;
    logic [NIRQ-1:0]  irq;
    logic [NIRQ-1:0]  irq_en;
    logic [CW-1:0]    idle_cnt;
    logic             idle_fired;
    logic             aw_got;
    logic             w_got;
    logic [AW-1:0]    awaddr;
    logic [31:0]      wdata;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } state_t;

  state_t r, n;

  // unpack synchronised inputs
  logic       hpd_pin, v23, v27, v40, host_busy, usb_act, fdet_on, field, gpio, card_ev;
  logic       aux, wcnt, ovl, pad_ok, deact_done;
  logic [2:0] card_ab;
  logic [1:0] hot;
  logic [3:0] hwake;
  always_comb begin
    {hpd_pin, v23, v27, v40, card_ab, hot, host_busy, usb_act, fdet_on, field, gpio,
     card_ev, aux, wcnt, ovl, pad_ok, deact_done} = r.s2;
  end
  // host wake lines come from same-clock interface logic
  assign hwake = HOST_WAKE;

  logic [NWAKE-1:0] wake_raw, wake_hit;
  logic             hpd_cond, hpd_exit, blocked, gpio_rise, host_w, brownout_detector, card_low, temp_ok;
  logic             wr_fire, rd_fire;
  logic [31:0]      rd_val;
  logic [1:0]       hsel;

  always_comb begin
    n = r;
    n.s1 = {HPD_PIN, MAIN_ABOVE_2V3, MAIN_ABOVE_2V7, MON_B_ABOVE_4V0, CARD_ABOVE, TEMP_HOT,
            HOST_BUSY, USB_ACTIVITY, FIELD_DET_ON, FIELD_PRESENT, GPIO_WAKE, CARD_EVENT,
            AUX_IRQ, WAKE_COUNTER, OVERLOAD, PAD_SUPPLY_OK, CT_DEACT_DONE};
    n.s2 = r.s1;
    n.gpio_d = gpio;
    hsel = r.ctrl[C_HOST_LO +: 2];
    gpio_rise = gpio & ~r.gpio_d;
    host_w = (r.mode == M_SUSPEND) ? (hsel == HOST_USB) & hwake[hsel]
                                   : (hsel != HOST_USB) & hwake[hsel];
    temp_ok = r.thermal & ~hot[0] & ~hot[1];
    wake_raw = '0;
    wake_raw[W_HOST]  = host_w;
    wake_raw[W_FIELD] = field;
    wake_raw[W_GPIO]  = gpio_rise;
    wake_raw[W_CARD]  = card_ev;
    wake_raw[W_AUX]   = aux;
    wake_raw[W_CNT]   = wcnt;
    wake_raw[W_OVER]  = ovl;
    wake_raw[W_TEMP]  = temp_ok;
    wake_hit = wake_raw & r.wake_en;
    brownout_detector = r.thr[T_BOD_LO] ? ~v27 : ~v23;
    hpd_cond = ~hpd_pin | (r.ctrl[C_AUTO_HPD] & (r.thr[T_HPD_LO] ? ~v27 : ~v23));
    hpd_exit = hpd_pin & v23;
    blocked = host_busy | (|wake_hit) | (r.wake_en[W_FIELD] & ~fdet_on) | ~pad_ok;
    card_low = ~card_ab[(r.thr[T_CARD_LO +: 2] > CARD_TOP) ? CARD_TOP : r.thr[T_CARD_LO +: 2]];

    if (usb_act) begin
      n.idle_cnt = '0;
      n.idle_fired = 1'b0;
    end else if (r.idle_cnt <= CW'(USB_IDLE)) begin
      n.idle_cnt = r.idle_cnt + 1'b1;
    end

    // request bits self-clear once acted upon
    case (r.mode)
      M_ACTIVE: begin
        if (r.ctrl[C_STBY_REQ] | r.ctrl[C_SUSP_REQ]) begin
          n.ctrl[C_STBY_REQ] = 1'b0;
          n.ctrl[C_SUSP_REQ] = 1'b0;
          if (!blocked) begin
            n.to_susp = ~r.ctrl[C_STBY_REQ];
            n.mode = M_DEACT;
          end
        end
      end
      M_DEACT: if (deact_done) begin
        n.mode = r.to_susp ? M_SUSPEND : M_STANDBY;
      end
      M_STANDBY, M_SUSPEND: if (|wake_hit) begin
        n.mode = M_ACTIVE;
        n.thermal = 1'b0;
      end
      M_HPD: if (hpd_exit) begin
        n.mode = M_ACTIVE;
      end
      default: n.mode = M_ACTIVE;
    endcase
    if (hpd_cond) begin
      n.mode = M_HPD;
    end

    // bus slave
    if (S_AXI_AWVALID & ~r.aw_got) begin
      n.aw_got = 1'b1;
      n.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID & ~r.w_got) begin
      n.w_got = 1'b1;
      n.wdata = S_AXI_WDATA;
    end
    wr_fire = r.aw_got & r.w_got & ~r.bvalid;
    if (wr_fire) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OK;
      case (r.awaddr)
        OFS_CTRL: if (S_AXI_WSTRB[0]) begin
          n.ctrl = r.wdata[7:0];
        end
        OFS_WAKEEN: if (S_AXI_WSTRB[0]) begin
          n.wake_en = r.wdata[NWAKE-1:0];
        end
        OFS_THR: if (S_AXI_WSTRB[0]) begin
          n.thr = r.wdata[5:0];
        end
        OFS_IRQ: if (S_AXI_WSTRB[0]) begin
          n.irq = r.irq & ~r.wdata[NIRQ-1:0];
        end
        OFS_IRQEN: if (S_AXI_WSTRB[0]) begin
          n.irq_en = r.wdata[NIRQ-1:0];
        end
        OFS_STAT: ;
        default: n.bresp = RESP_ERR;
      endcase
    end
    if (r.bvalid & S_AXI_BREADY) begin
      n.bvalid = 1'b0;
    end

    // events set after clears, so set wins
    // idle event
    if (!usb_act && r.idle_cnt > CW'(USB_IDLE) && !r.idle_fired) begin
      n.irq[I_USB] = 1'b1;
      n.idle_fired = 1'b1;
    end
    if (brownout_detector) begin
      n.irq[I_BOD] = 1'b1;
    end
    if (card_low) begin
      n.irq[I_CARD] = 1'b1;
    end
    if (hot[0]) begin
      n.irq[I_T0] = 1'b1;
    end
    if (hot[1]) begin
      n.irq[I_T1] = 1'b1;
    end
    if (|hot && r.mode == M_ACTIVE) begin
      n.thermal = 1'b1;
    end

    rd_fire = S_AXI_ARVALID & ~r.rvalid;
    rd_val = '0;
    case (S_AXI_ARADDR)
      OFS_CTRL:   rd_val[7:0] = r.ctrl;
      OFS_WAKEEN: rd_val[NWAKE-1:0] = r.wake_en;
      OFS_THR:    rd_val[5:0] = r.thr;
      OFS_STAT:   rd_val[11:0] = {v40, card_low, brownout_detector, ~v27, ~v23, hot, r.thermal,
                                  1'b0, r.mode};
      OFS_IRQ:    rd_val[NIRQ-1:0] = r.irq;
      OFS_IRQEN:  rd_val[NIRQ-1:0] = r.irq_en;
      default:    rd_val = '0;
    endcase
    if (rd_fire) begin
      n.rvalid = 1'b1;
      n.rdata = rd_val;
      n.rresp = (S_AXI_ARADDR > OFS_IRQEN || S_AXI_ARADDR[1:0] != 2'h0) ? RESP_ERR : RESP_OK;
    end else if (r.rvalid & S_AXI_RREADY) begin
      n.rvalid = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      r <= '0;
      r.s1 <= SYNC_IDLE;
      r.s2 <= SYNC_IDLE;
      r.mode <= M_ACTIVE;
      r.ctrl[C_PAD_LO +: 2] <= PAD_LOWPWR;
      r.thr[T_TEMP_LO +: 2] <= TEMP_120;
    end else begin
      r <= n;
    end
  end

  assign S_AXI_AWREADY = ~r.aw_got;
  assign S_AXI_WREADY  = ~r.w_got;
  assign S_AXI_BVALID  = r.bvalid;
  assign S_AXI_BRESP   = r.bresp;
  assign S_AXI_ARREADY = ~r.rvalid;
  assign S_AXI_RVALID  = r.rvalid;
  assign S_AXI_RDATA   = r.rdata;
  assign S_AXI_RRESP   = r.rresp;
  assign MODE          = r.mode;
  assign FAST_CLKS_ON    = (r.mode == M_ACTIVE) | (r.mode == M_DEACT);
  assign SLOW_OSC_ON     = (r.mode != M_HPD);
  assign MAIN_REG_LOWPWR = (r.mode == M_STANDBY) | (r.mode == M_SUSPEND) | (r.mode == M_HPD);
  assign OTHER_REGS_ON   = (r.mode != M_HPD);
  assign PAD_REG_MODE = (r.mode == M_HPD) ? PAD_OFF :
                        (r.mode == M_STANDBY || r.mode == M_SUSPEND) ? r.ctrl[C_PAD_LO +: 2]
                        : PAD_ACTIVE;
  assign CT_DEACT_REQ = (r.mode == M_DEACT) | (r.ctrl[C_CT_AUTO] & card_low);
  assign CPU_IRQ      = |(r.irq & r.irq_en);

  // hard power-down reached on the edge after hpd_cond
  AST_HPD_ENTRY: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    hpd_cond |=> r.mode == M_HPD) else $error("hpd not entered");
  AST_HPD_EXIT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (r.mode == M_HPD && !hpd_exit) |=> r.mode == M_HPD) else $error("hpd left early");
  AST_REFUSE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (r.mode == M_ACTIVE && blocked && !hpd_cond) |=> r.mode != M_DEACT)
    else $error("low-power entry not refused");
  sequence s_deact;
    r.mode == M_DEACT ##1 r.mode != M_DEACT;
  endsequence
  AST_DEACT_FIRST: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ($rose(r.mode == M_STANDBY) || $rose(r.mode == M_SUSPEND)) |-> $past(r.mode) == M_DEACT)
    else $error("entry without deactivation");
  AST_SUSP_CLK: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    r.mode == M_SUSPEND |-> !FAST_CLKS_ON && SLOW_OSC_ON) else $error("suspend clocks");
  AST_HPD_OUT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    r.mode == M_HPD |-> !OTHER_REGS_ON && MAIN_REG_LOWPWR && !SLOW_OSC_ON)
    else $error("hpd supplies");
  AST_WAKE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (r.mode == M_STANDBY && |wake_hit && !hpd_cond) |=> r.mode == M_ACTIVE)
    else $error("no wake");
  AST_GPIO_EDGE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (r.mode == M_STANDBY && r.wake_en == (1 << W_GPIO) && !(gpio && !r.gpio_d) && !hpd_cond)
    |=> r.mode == M_STANDBY) else $error("gpio woke without edge");
  AST_IRQ_OUT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (hot[0] && r.irq_en[I_T0]) |=> CPU_IRQ && r.irq[I_T0]) else $error("temp irq");
endmodule

// ==== tb/tb_pwr_mode_sup.sv ====
// bench for the power-mode supervisor: entry, refusal, wake, hard power-down, irqs.
// assumes the AXI4-Lite slave of pwr_mode_sup and a shortened usb idle count.
`timescale 1ns/1ps
module tb_pwr_mode_sup;
  import pwr_mode_pkg::*;
  localparam int unsigned IDLE = 20;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic [AW-1:0] awa = '0, ara = '0;
  logic [31:0]   wd = '0, rd;
  logic [3:0]    ws = 4'h0, hw = 4'h0;
  logic          awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic          awr, wr, bv, arr, rv, ct_req, fclk, sosc, mlp, oregs, irq;
  logic [1:0]    bresp, rresp, padm, hot = 2'h0;
  logic [2:0]    mode, card = 3'h7;
  logic          hard_powerdown_mode = 1, a23 = 1, a27 = 1, b40 = 1, hb = 0, usb = 1, fdon = 1, fpr = 0;
  logic          gpio = 0, cev = 0, aux = 0, wcnt = 0, ovl = 0, pad_ok = 1, done = 0;
  int            failures = 0;
  int            tests_run = 0;
  logic [31:0]   d;

  always #2 clk = ~clk;

  pwr_mode_sup #(.USB_IDLE(IDLE)) u_dut (
    .SYS_CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
    .HPD_PIN(hard_powerdown_mode), .MAIN_ABOVE_2V3(a23), .MAIN_ABOVE_2V7(a27), .MON_B_ABOVE_4V0(b40),
    .CARD_ABOVE(card), .TEMP_HOT(hot), .HOST_BUSY(hb), .HOST_WAKE(hw),
    .USB_ACTIVITY(usb), .FIELD_DET_ON(fdon), .FIELD_PRESENT(fpr), .GPIO_WAKE(gpio),
    .CARD_EVENT(cev), .AUX_IRQ(aux), .WAKE_COUNTER(wcnt), .OVERLOAD(ovl),
    .PAD_SUPPLY_OK(pad_ok), .CT_DEACT_DONE(done), .CT_DEACT_REQ(ct_req), .MODE(mode),
    .FAST_CLKS_ON(fclk), .SLOW_OSC_ON(sosc), .MAIN_REG_LOWPWR(mlp),
    .PAD_REG_MODE(padm), .OTHER_REGS_ON(oregs), .CPU_IRQ(irq)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ready is sampled mid-cycle; it only changes on rising edges
  task automatic wr_reg(input logic [AW-1:0] a, input logic [31:0] v, input logic [1:0] er);
    logic la, lw, lb;
    logic [1:0] r;
    r = 2'h3;
    @(posedge clk);
    awa <= a; wd <= v; ws <= 4'hf; awv <= 1; wv <= 1; br <= 1;
    repeat (200) begin
      @(negedge clk);
      la = awv && awr;
      lw = wv && wr;
      lb = br && bv;
      if (lb) r = bresp;
      @(posedge clk);
      if (la) awv <= 0;
      if (lw) wv <= 0;
      if (lb) begin
        br <= 0;
        break;
      end
    end
    chk(32'(r), 32'(er));
  endtask

  task automatic rd_reg(input logic [AW-1:0] a, input logic [1:0] er);
    logic la, lr;
    logic [1:0] r;
    r = 2'h3;
    @(posedge clk);
    ara <= a; arv <= 1; rr <= 1;
    repeat (200) begin
      @(negedge clk);
      la = arv && arr;
      lr = rr && rv;
      if (lr) begin
        r = rresp;
        d = rd;
      end
      @(posedge clk);
      if (la) arv <= 0;
      if (lr) begin
        rr <= 0;
        break;
      end
    end
    chk(32'(r), 32'(er));
  endtask

  task automatic wait_mode(input mode_t m);
    repeat (60) begin
      @(negedge clk);
      if (mode === m) break;
    end
    chk(32'(mode), 32'(m));
  endtask

  task automatic stay(input mode_t m);
    repeat (8) @(negedge clk);
    chk(32'(mode), 32'(m));
  endtask

  task automatic enter(input logic [7:0] c, input mode_t m);
    wr_reg(OFS_CTRL, {24'h0, c}, RESP_OK);
    wait_mode(M_DEACT);
    chk(32'(ct_req), 32'h1);
    @(posedge clk) done <= 1;
    wait_mode(m);
    @(posedge clk) done <= 0;
  endtask

  task automatic t_reset;
    chk(32'(mode), 32'(M_ACTIVE));
    rd_reg(OFS_THR, RESP_OK);
    chk(d & 32'h30, 32'h30);
    rd_reg(8'h40, RESP_ERR);
    chk(d, 32'h0);
    wr_reg(8'h40, 32'h1, RESP_ERR);
    $display("test reset done");
  endtask

  task automatic t_refuse;
    for (int i = 0; i < 4; i++) begin
      wr_reg(OFS_WAKEEN, (i == 1 || i == 2) ? 32'h2 : 32'h0, RESP_OK);
      @(posedge clk);
      hb <= (i == 0); fdon <= (i != 1); fpr <= (i == 2); pad_ok <= (i != 3);
      repeat (4) @(posedge clk);
      wr_reg(OFS_CTRL, i[0] ? 32'h6 : 32'h5, RESP_OK);
      stay(M_ACTIVE);
      rd_reg(OFS_CTRL, RESP_OK);
      chk(d & 32'h3, 32'h0);
      @(posedge clk);
      hb <= 0; fdon <= 1; fpr <= 0; pad_ok <= 1;
    end
    $display("test refuse done");
  endtask

  task automatic set_src(input int s, input logic v);
    case (s)
      W_GPIO:  gpio <= v;
      W_CARD:  cev <= v;
      W_AUX:   aux <= v;
      W_CNT:   wcnt <= v;
      default: ovl <= v;
    endcase
  endtask

  task automatic t_wake;
    int src[5] = '{W_GPIO, W_CARD, W_AUX, W_CNT, W_OVER};
    logic [1:0] pm[5] = '{PAD_LOWPWR, PAD_ACTIVE, PAD_LOWPWR, PAD_LOWPWR, PAD_OFF};
    for (int i = 0; i < 5; i++) begin
      wr_reg(OFS_WAKEEN, 32'h1 << src[i], RESP_OK);
      enter({4'h0, pm[i], 2'b01}, M_STANDBY);
      chk(32'({fclk, sosc, mlp}), 32'h3);
      chk(32'(padm), 32'(pm[i]));
      stay(M_STANDBY);
      @(posedge clk) set_src(src[i], 1'b1);
      wait_mode(M_ACTIVE);
      @(posedge clk) set_src(src[i], 1'b0);
      repeat (4) @(posedge clk);
    end
    $display("test wake done");
  endtask

  task automatic t_suspend;
    wr_reg(OFS_WAKEEN, 32'h1 << W_HOST, RESP_OK);
    enter({HOST_USB, 4'h1, 2'b10}, M_SUSPEND);
    chk(32'({fclk, sosc}), 32'h1);
    @(posedge clk) hw <= 4'h1;
    stay(M_SUSPEND);
    @(posedge clk) hw <= 4'h8;
    wait_mode(M_ACTIVE);
    @(posedge clk) hw <= 4'h0;
    $display("test suspend done");
  endtask

  task automatic t_irq;
    wr_reg(OFS_IRQEN, 32'h1, RESP_OK);
    @(posedge clk) usb <= 0;
    repeat (IDLE / 2) @(negedge clk);
    chk(32'(irq), 32'h0);
    repeat (IDLE) @(negedge clk);
    chk(32'(irq), 32'h1);
    wr_reg(OFS_IRQ, 32'h1, RESP_OK);
    repeat (4) @(negedge clk);
    chk(32'(irq), 32'h0);
    wr_reg(OFS_THR, 32'h31, RESP_OK);
    wr_reg(OFS_IRQEN, 32'h6, RESP_OK);
    wr_reg(OFS_CTRL, 32'h24, RESP_OK);
    @(posedge clk);
    usb <= 1; a27 <= 0; card <= 3'h6; b40 <= 0;
    repeat (6) @(negedge clk);
    chk(32'(irq), 32'h1);
    chk(32'(ct_req), 32'h1);
    rd_reg(OFS_IRQ, RESP_OK);
    chk(d & 32'h6, 32'h6);
    rd_reg(OFS_STAT, RESP_OK);
    chk(d & 32'hf80, 32'h700);
    @(posedge clk);
    a27 <= 1; card <= 3'h7; b40 <= 1;
    repeat (4) @(posedge clk);
    wr_reg(OFS_IRQ, 32'h1f, RESP_OK);
    chk(32'(irq), 32'h0);
    chk(32'(ct_req), 32'h0);
    $display("test irq done");
  endtask

  task automatic t_temp;
    wr_reg(OFS_WAKEEN, 32'h1 << W_TEMP, RESP_OK);
    @(posedge clk) hot <= 2'h1;
    repeat (6) @(posedge clk);
    rd_reg(OFS_IRQ, RESP_OK);
    chk(d & 32'h18, 32'h08);
    enter(8'h05, M_STANDBY);
    @(posedge clk) hot <= 2'h2;
    stay(M_STANDBY);
    @(posedge clk) hot <= 2'h0;
    wait_mode(M_ACTIVE);
    $display("test temp done");
  endtask

  task automatic t_hpd;
    @(posedge clk) hard_powerdown_mode <= 0;
    wait_mode(M_HPD);
    chk(32'({fclk, sosc, mlp, oregs}), 32'h2);
    @(posedge clk);
    a23 <= 0; hard_powerdown_mode <= 1;
    stay(M_HPD);
    @(posedge clk) a23 <= 1;
    wait_mode(M_ACTIVE);
    wr_reg(OFS_WAKEEN, 32'h0, RESP_OK);
    enter(8'h05, M_STANDBY);
    @(posedge clk) hard_powerdown_mode <= 0;
    wait_mode(M_HPD);
    @(posedge clk) hard_powerdown_mode <= 1;
    wait_mode(M_ACTIVE);
    wr_reg(OFS_CTRL, 32'h14, RESP_OK);
    wr_reg(OFS_THR, 32'h32, RESP_OK);
    @(posedge clk) a27 <= 0;
    wait_mode(M_HPD);
    @(posedge clk) a27 <= 1;
    wait_mode(M_ACTIVE);
    stay(M_ACTIVE);
    $display("test hpd done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_refuse();
    t_wake();
    t_suspend();
    t_irq();
    t_temp();
    t_hpd();
    complete_run();
  end

  // whole run needs well under a thousand cycles; this is 25000 cycles, many times that
  initial begin
    #100000;
    failures++;
    $display("BAD %0t watchdog expired", $time);
    complete_run();
  end
endmodule
